/* dealloc_cfg.svh */
// widths, field positions, codes and deallocated-block fill values for the deallocate / flush / read block
`ifndef DEALLOC_CFG_SVH
`define DEALLOC_CFG_SVH
`define OPC_WIDTH 2
`define LBA_WIDTH 64
`define DW12_RETRY_BIT 31
`define DW12_FORCE_BIT 30
`define DW12_PROT_HI 29
`define DW12_PROT_LO 26
`define DW12_COUNT_HI 15
`define DW12_COUNT_LO 0
`define DEALLOC_READ_FEATURE_CODE_ZEROS 3'h1
`define DEALLOC_READ_FEATURE_CODE_ONES 3'h2
`define GUARD_ONES 16'hffff
`define GUARD_ZERO 16'h0000
`define APP_TAG_ONES 16'hffff
`define REF_TAG_ONES 32'h0fff_ffff
`define STATUS_SUCCESS 8'h00
`define STATUS_CONFLICT 8'h80
`define STATUS_READ_ONLY 8'h82
`define STATUS_UNWRITTEN 8'h87
`define SCT_GENERIC 3'h0
`define SCT_CMD_SPECIFIC 3'h1
`define SCT_MEDIA 3'h2
`endif

/* dealloc_pkg.sv */
// types shared by the deallocate / flush / read block
package dealloc_pkg;
    typedef enum logic [1:0] {
        op_read,
        op_write,
        op_dealloc,
        op_flush
    } opcode_t;

    typedef enum logic [1:0] {
        pat_zeros,
        pat_ones,
        pat_last_written
    } pattern_t;
endpackage

/* dealloc_flag_mem.sv */
// per-block deallocated flag memory, one bit per block, registered read
module dealloc_flag_mem #(
    parameter int ADDR_W = 10
) (
    // clock
    input wire logic clk,
    // write port
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic wr_data,
    // read port
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic rd_data
);
    logic mem [0:(1<<ADDR_W)-1];

    // no reset on the array: the owner sets every flag by a walk after reset and after sanitize
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

/* dealloc_flush_read_cmd.sv */
// command interpreter for deallocate, flush and read with deallocated-block handling
`include "dealloc_cfg.svh"

module dealloc_flush_read_cmd
    import dealloc_pkg::*;
#(
    parameter int ADDR_W = 10,
    parameter int COUNT_W = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // static configuration
    input wire logic [2:0] dealloc_read_feature_code,
    input wire logic cache_enabled,
    input wire logic unwritten_err_supported,
    input wire logic unwritten_err_enabled,
    // command submission
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire dealloc_pkg::opcode_t cmd_opcode,
    input wire logic cmd_sgl,
    input wire logic [31:0] cmd_dword10,
    input wire logic [31:0] cmd_dword11,
    input wire logic [31:0] cmd_dword12,
    input wire logic [COUNT_W-1:0] range_length,
    input wire logic attr_conflict,
    input wire logic range_read_only,
    // media and cache side
    output logic flush_req,
    input wire logic flush_done,
    input wire logic sanitize_done,
    // read result toward the data path
    output logic rd_info_valid,
    output logic [`LBA_WIDTH-1:0] first_block_address,
    output logic [16:0] blocks_to_read,
    output logic limited_retry_bit,
    output logic force_media_access_bit,
    output logic [3:0] protection_action_field,
    output logic uses_second_page_entry,
    output logic blk_valid,
    output logic blk_deallocated,
    output dealloc_pkg::pattern_t blk_pattern,
    output logic [15:0] blk_guard,
    output logic [15:0] blk_app_tag,
    output logic [31:0] blk_ref_tag,
    // completion
    output logic cpl_valid,
    output logic [2:0] cpl_sct,
    output logic [7:0] cpl_status
);
    import dealloc_pkg::*;

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        st_clear,
        st_idle,
        st_walk,
        st_look,
        st_flush,
        st_done
    } state_t;

    state_t state_q, state_d;
    opcode_t op_q, op_d;
    logic [`LBA_WIDTH-1:0] lba_q, lba_d;
    logic [`LBA_WIDTH-1:0] first_block_address_q, first_block_address_d; // start address stands while lba_q walks
    logic [COUNT_W-1:0] left_q, left_d;
    logic [ADDR_W-1:0] clr_q, clr_d;
    logic rd_hit_q, rd_hit_d;
    logic cmd_ready_q, cmd_ready_d;
    logic flush_req_q, flush_req_d;
    logic rd_info_valid_q, rd_info_valid_d;
    logic [16:0] nlb_q, nlb_d;
    logic lr_q, lr_d;
    logic fua_q, fua_d;
    logic [3:0] prot_q, prot_d;
    logic page2_q, page2_d;
    logic blk_valid_q, blk_valid_d;
    logic blk_dealloc_q, blk_dealloc_d;
    pattern_t blk_pat_q, blk_pat_d;
    logic [15:0] guard_q, guard_d;
    logic [15:0] app_q, app_d;
    logic [31:0] ref_q, ref_d;
    logic cpl_valid_q, cpl_valid_d;
    logic [2:0] sct_q, sct_d;
    logic [7:0] status_q, status_d;
    logic look_q, look_d;

    // flag memory ports
    logic mem_we;
    logic [ADDR_W-1:0] mem_waddr;
    logic mem_wdata;
    logic [ADDR_W-1:0] mem_raddr;
    logic mem_rdata;

    // pattern chosen for deallocated reads from the advertised feature code
    function automatic pattern_t pick_pattern(input logic [2:0] code);
        case (code)
            `DEALLOC_READ_FEATURE_CODE_ZEROS: pick_pattern = pat_zeros;
            `DEALLOC_READ_FEATURE_CODE_ONES: pick_pattern = pat_ones;
            default: pick_pattern = pat_zeros; // zeros also scrub pre-sanitize data
        endcase
    endfunction

    dealloc_flag_mem #(
        .ADDR_W(ADDR_W)
    ) u_flags (
        .clk(clk),
        .wr_en(mem_we),
        .wr_addr(mem_waddr),
        .wr_data(mem_wdata),
        .rd_addr(mem_raddr),
        .rd_data(mem_rdata)
    );

    // -------------------------------------------------------------
    // next-state logic
    // -------------------------------------------------------------
    // one command at a time, so a flush taken here already follows every
    // earlier completion
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        lba_d = lba_q;
        first_block_address_d = first_block_address_q;
        left_d = left_q;
        clr_d = clr_q;
        rd_hit_d = rd_hit_q;
        cmd_ready_d = 1'b0;
        flush_req_d = flush_req_q;
        rd_info_valid_d = 1'b0;
        nlb_d = nlb_q;
        lr_d = lr_q;
        fua_d = fua_q;
        prot_d = prot_q;
        page2_d = page2_q;
        blk_valid_d = 1'b0;
        blk_dealloc_d = blk_dealloc_q;
        blk_pat_d = blk_pat_q;
        guard_d = guard_q;
        app_d = app_q;
        ref_d = ref_q;
        cpl_valid_d = 1'b0;
        sct_d = sct_q;
        status_d = status_q;
        look_d = 1'b0;
        mem_we = 1'b0;
        mem_waddr = lba_q[ADDR_W-1:0];
        mem_wdata = 1'b0;
        mem_raddr = lba_q[ADDR_W-1:0];
        case (state_q)
            st_clear: begin
                // after reset (and after sanitize) every block reads deallocated
                mem_we = 1'b1;
                mem_waddr = clr_q;
                mem_wdata = 1'b1;
                clr_d = clr_q + 1'b1;
                if (clr_q == {ADDR_W{1'b1}}) begin
                    state_d = st_idle;
                    cmd_ready_d = 1'b1;
                end
            end
            st_idle: begin
                cmd_ready_d = 1'b1;
                if (sanitize_done) begin
                    state_d = st_clear;
                    clr_d = '0;
                    cmd_ready_d = 1'b0;
                end else if (cmd_valid && cmd_ready_q) begin
                    cmd_ready_d = 1'b0;
                    op_d = cmd_opcode;
                    lba_d = {cmd_dword11, cmd_dword10};
                    first_block_address_d = {cmd_dword11, cmd_dword10};
                    status_d = `STATUS_SUCCESS;
                    sct_d = `SCT_GENERIC;
                    rd_hit_d = 1'b0;
                    case (cmd_opcode)
                        op_read: begin
                            nlb_d = {1'b0, cmd_dword12[`DW12_COUNT_HI:`DW12_COUNT_LO]} + 17'd1;
                            left_d = COUNT_W'(cmd_dword12[`DW12_COUNT_HI:`DW12_COUNT_LO]) + 1'b1;
                            lr_d = cmd_dword12[`DW12_RETRY_BIT];
                            fua_d = cmd_dword12[`DW12_FORCE_BIT];
                            prot_d = cmd_dword12[`DW12_PROT_HI:`DW12_PROT_LO];
                            page2_d = ~cmd_sgl;
                            rd_info_valid_d = 1'b1;
                            state_d = st_look;
                        end
                        op_write: begin
                            left_d = COUNT_W'(cmd_dword12[`DW12_COUNT_HI:`DW12_COUNT_LO]) + 1'b1;
                            state_d = st_walk;
                        end
                        op_dealloc: begin
                            left_d = range_length;
                            if (attr_conflict) begin
                                sct_d = `SCT_CMD_SPECIFIC;
                                status_d = `STATUS_CONFLICT;
                                state_d = st_done;
                            end else if (range_read_only) begin
                                sct_d = `SCT_CMD_SPECIFIC;
                                status_d = `STATUS_READ_ONLY;
                                state_d = st_done;
                            end else if (range_length == '0) begin
                                state_d = st_done;
                            end else begin
                                state_d = st_walk;
                            end
                        end
                        default: begin
                            if (cache_enabled) begin
                                flush_req_d = 1'b1;
                                state_d = st_flush;
                            end else begin
                                state_d = st_done;
                            end
                        end
                    endcase
                end
            end
            st_walk: begin
                // write clears, deallocate sets the per-block flag
                mem_we = 1'b1;
                mem_wdata = (op_q == op_dealloc);
                lba_d = lba_q + 1'b1;
                left_d = left_q - 1'b1;
                if (left_q == COUNT_W'(1)) begin
                    state_d = st_done;
                end
            end
            st_look: begin
                // read only looks up the flag, never writes it
                look_d = 1'b1;
                lba_d = lba_q + 1'b1;
                left_d = left_q - 1'b1;
                if (left_q == COUNT_W'(1)) begin
                    state_d = st_done;
                end
            end
            st_flush: begin
                if (flush_done) begin
                    flush_req_d = 1'b0;
                    state_d = st_done;
                end
            end
            st_done: begin
                // wait one cycle so the last lookup result has landed
                if (!look_q) begin
                    cpl_valid_d = 1'b1;
                    if (op_q == op_read && rd_hit_q && unwritten_err_supported
                        && unwritten_err_enabled) begin
                        sct_d = `SCT_MEDIA;
                        status_d = `STATUS_UNWRITTEN;
                    end
                    state_d = st_idle;
                    cmd_ready_d = 1'b1;
                end
            end
            default: begin
                state_d = st_idle;
            end
        endcase
        // registered flag from last cycle's lookup
        if (look_q) begin
            blk_valid_d = 1'b1;
            blk_dealloc_d = mem_rdata;
            if (mem_rdata) begin
                rd_hit_d = 1'b1;
                blk_pat_d = pick_pattern(dealloc_read_feature_code);
                guard_d = (pick_pattern(dealloc_read_feature_code) == pat_zeros)
                    ? `GUARD_ZERO : `GUARD_ONES;
                app_d = `APP_TAG_ONES;
                ref_d = `REF_TAG_ONES;
            end else begin
                blk_pat_d = pat_last_written;
                guard_d = `GUARD_ZERO;
                app_d = 16'h0000;
                ref_d = 32'h0000_0000;
            end
        end
    end

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= st_clear;
            op_q <= op_read;
            lba_q <= '0;
            first_block_address_q <= '0;
            left_q <= '0;
            clr_q <= '0;
            rd_hit_q <= 1'b0;
            cmd_ready_q <= 1'b0;
            flush_req_q <= 1'b0;
            rd_info_valid_q <= 1'b0;
            nlb_q <= '0;
            lr_q <= 1'b0;
            fua_q <= 1'b0;
            prot_q <= '0;
            page2_q <= 1'b0;
            blk_valid_q <= 1'b0;
            blk_dealloc_q <= 1'b0;
            blk_pat_q <= pat_zeros;
            guard_q <= '0;
            app_q <= '0;
            ref_q <= '0;
            cpl_valid_q <= 1'b0;
            sct_q <= '0;
            status_q <= '0;
            look_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            lba_q <= lba_d;
            first_block_address_q <= first_block_address_d;
            left_q <= left_d;
            clr_q <= clr_d;
            rd_hit_q <= rd_hit_d;
            cmd_ready_q <= cmd_ready_d;
            flush_req_q <= flush_req_d;
            rd_info_valid_q <= rd_info_valid_d;
            nlb_q <= nlb_d;
            lr_q <= lr_d;
            fua_q <= fua_d;
            prot_q <= prot_d;
            page2_q <= page2_d;
            blk_valid_q <= blk_valid_d;
            blk_dealloc_q <= blk_dealloc_d;
            blk_pat_q <= blk_pat_d;
            guard_q <= guard_d;
            app_q <= app_d;
            ref_q <= ref_d;
            cpl_valid_q <= cpl_valid_d;
            sct_q <= sct_d;
            status_q <= status_d;
            look_q <= look_d;
        end
    end

    // outputs straight from flops
    assign cmd_ready = cmd_ready_q;
    assign flush_req = flush_req_q;
    assign rd_info_valid = rd_info_valid_q;
    assign first_block_address = first_block_address_q;
    assign blocks_to_read = nlb_q;
    assign limited_retry_bit = lr_q;
    assign force_media_access_bit = fua_q;
    assign protection_action_field = prot_q;
    assign uses_second_page_entry = page2_q;
    assign blk_valid = blk_valid_q;
    assign blk_deallocated = blk_dealloc_q;
    assign blk_pattern = blk_pat_q;
    assign blk_guard = guard_q;
    assign blk_app_tag = app_q;
    assign blk_ref_tag = ref_q;
    assign cpl_valid = cpl_valid_q;
    assign cpl_sct = sct_q;
    assign cpl_status = status_q;
endmodule

/* dealloc_checker_assertions.sv */
// concurrent checks on the ports of the deallocate / flush / read block
`include "dealloc_cfg.svh"
module dealloc_checker
    import dealloc_pkg::*;
#(
    parameter int ADDR_W = 10,
    parameter int COUNT_W = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration and command
    input wire logic [2:0] dealloc_read_feature_code,
    input wire logic cache_enabled,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire dealloc_pkg::opcode_t cmd_opcode,
    input wire logic cmd_sgl,
    input wire logic [31:0] cmd_dword10,
    input wire logic [31:0] cmd_dword11,
    input wire logic [31:0] cmd_dword12,
    input wire logic attr_conflict,
    // flush link
    input wire logic flush_req,
    input wire logic flush_done,
    // read results
    input wire logic rd_info_valid,
    input wire logic [`LBA_WIDTH-1:0] first_block_address,
    input wire logic [16:0] blocks_to_read,
    input wire logic limited_retry_bit,
    input wire logic force_media_access_bit,
    input wire logic [3:0] protection_action_field,
    input wire logic uses_second_page_entry,
    input wire logic blk_valid,
    input wire logic blk_deallocated,
    input wire dealloc_pkg::pattern_t blk_pattern,
    input wire logic [15:0] blk_guard,
    input wire logic [15:0] blk_app_tag,
    input wire logic [31:0] blk_ref_tag,
    // completion
    input wire logic cpl_valid,
    input wire logic [2:0] cpl_sct,
    input wire logic [7:0] cpl_status
);
    // ----------------------------------------
    // handshake, flush, read field and deallocate status checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic take;
    // a command is taken only where both sides agree at one edge
    assign take = cmd_valid && cmd_ready;

    a_ready_drops: assert property (take |=> !cmd_ready)
        else $error("ready stayed high after a take");
    a_flush_starts: assert property (take && cmd_opcode == op_flush && cache_enabled |=> flush_req)
        else $error("flush with cache did not request a commit");
    a_flush_nop: assert property (take && cmd_opcode == op_flush && !cache_enabled |=> !flush_req
        ##1 (cpl_valid && cpl_status == `STATUS_SUCCESS && cpl_sct == `SCT_GENERIC))
        else $error("flush without cache did not complete at once");
    a_flush_holds: assert property (flush_req |-> !cpl_valid)
        else $error("flush completed while commit pending");
    a_flush_done_cpl: assert property (flush_req && flush_done |=> !flush_req ##1 cpl_valid)
        else $error("flush did not complete after commit");
    a_read_fields: assert property (take && cmd_opcode == op_read |=> rd_info_valid
        && first_block_address == {$past(cmd_dword11), $past(cmd_dword10)}
        && blocks_to_read == 17'($past(cmd_dword12[15:0])) + 17'd1
        && limited_retry_bit == $past(cmd_dword12[`DW12_RETRY_BIT])
        && force_media_access_bit == $past(cmd_dword12[`DW12_FORCE_BIT])
        && protection_action_field == $past(cmd_dword12[`DW12_PROT_HI:`DW12_PROT_LO])
        && uses_second_page_entry == !$past(cmd_sgl))
        else $error("read fields decoded wrongly");
    a_dealloc_tags: assert property (blk_valid && blk_deallocated |->
        blk_app_tag == `APP_TAG_ONES && blk_ref_tag == `REF_TAG_ONES)
        else $error("deallocated block tags wrong");
    a_guard_pattern: assert property (blk_valid && blk_deallocated |->
        blk_pattern == (dealloc_read_feature_code == `DEALLOC_READ_FEATURE_CODE_ONES ? pat_ones : pat_zeros)
        && blk_guard == (blk_pattern == pat_ones ? `GUARD_ONES : `GUARD_ZERO))
        else $error("deallocated pattern or guard wrong");
    a_conflict_status: assert property (take && cmd_opcode == op_dealloc && attr_conflict |->
        ##2 (cpl_valid && cpl_sct == `SCT_CMD_SPECIFIC && cpl_status == `STATUS_CONFLICT))
        else $error("conflict status missing");
    a_cpl_ready: assert property (cpl_valid |-> cmd_ready ##1 !cpl_valid)
        else $error("completion not a single pulse with ready");
endmodule

/* flush_media_model.sv */
// media and cache side model: answers each flush request after a set delay
module flush_media_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // flush link
    input wire logic flush_req,
    output logic flush_done,
    // control and observation
    input wire logic [7:0] delay,
    output int flushes
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // commit engine
    // ----------------------------------------
    // one request at a time; the request falls the edge after done is seen
    initial begin
        flush_done = 1'b0;
        flushes = 0;
        forever begin
            @(posedge clk);
            if (flush_req === 1'b1 && rst === 1'b0) begin
                flushes++;
                repeat (delay) @(posedge clk); // cache of every namespace drains here
                flush_done <= 1'b1;
                @(posedge clk);
                flush_done <= 1'b0;
            end
        end
    end
endmodule

/* testbench.sv */
// self-checking bench for the deallocate / flush / read block
`include "dealloc_cfg.svh"
module testbench;
    import dealloc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    localparam int AW = 4; // short flag walk after reset and sanitize
    logic clk, rst, cmd_valid, cmd_ready, cmd_sgl, attr_conflict, range_read_only;
    logic cache_enabled, unwritten_err_supported, unwritten_err_enabled, sanitize_done;
    logic flush_req, flush_done, rd_info_valid, limited_retry_bit, force_media_access_bit;
    logic uses_second_page_entry, blk_valid, blk_deallocated, cpl_valid;
    logic [2:0] dealloc_read_feature_code, cpl_sct, got_sct;
    logic [31:0] cmd_dword10, cmd_dword11, cmd_dword12, range_length, blk_ref_tag;
    logic [63:0] first_block_address;
    logic [16:0] blocks_to_read;
    logic [3:0] protection_action_field;
    logic [15:0] blk_guard, blk_app_tag;
    logic [7:0] cpl_status, got_status, delay;
    opcode_t cmd_opcode;
    pattern_t blk_pattern;
    int failures = 0, comparisons = 0, cycles = 0, flushes, n_before;
    logic dq[$];
    logic [15:0] gq[$];
    pattern_t pq[$];

    dealloc_flush_read_cmd #(.ADDR_W(AW)) uut (.clk, .rst, .dealloc_read_feature_code,
        .cache_enabled, .unwritten_err_supported, .unwritten_err_enabled, .cmd_valid, .cmd_ready,
        .cmd_opcode, .cmd_sgl, .cmd_dword10, .cmd_dword11, .cmd_dword12, .range_length,
        .attr_conflict, .range_read_only, .flush_req, .flush_done, .sanitize_done, .rd_info_valid,
        .first_block_address, .blocks_to_read, .limited_retry_bit, .force_media_access_bit,
        .protection_action_field, .uses_second_page_entry, .blk_valid, .blk_deallocated,
        .blk_pattern, .blk_guard, .blk_app_tag, .blk_ref_tag, .cpl_valid, .cpl_sct, .cpl_status);
    flush_media_model fm (.clk, .rst, .flush_req, .flush_done, .delay, .flushes);

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one command: hold it until taken, gather per-block results until completion
    task automatic run_cmd(input opcode_t op, input logic [63:0] lba, input logic [31:0] d12,
                           input logic [31:0] len = 0, input logic [1:0] errs = 0);
        int n;
        dq.delete();
        pq.delete();
        gq.delete();
        cmd_valid <= 1'b1;
        cmd_opcode <= op;
        {cmd_dword11, cmd_dword10} <= lba;
        cmd_dword12 <= d12;
        range_length <= len;
        {attr_conflict, range_read_only} <= errs;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 100);
        cmd_valid <= 1'b0;
        do begin
            @(posedge clk);
            n++;
            if (blk_valid === 1'b1) begin
                dq.push_back(blk_deallocated);
                pq.push_back(blk_pattern);
                gq.push_back(blk_guard);
            end
        end while (cpl_valid !== 1'b1 && n < 200);
        check(cpl_valid, 1'b1);
        got_status = cpl_status;
        got_sct = cpl_sct;
    endtask

    // ----------------------------------------
    // clock, watchdog and test sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // a hang counts as a mismatch and still reaches the verdict
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        rst = 1'b1;
        {cmd_valid, cmd_sgl, attr_conflict, range_read_only, sanitize_done} = '0;
        {cache_enabled, unwritten_err_supported, unwritten_err_enabled} = '0;
        {cmd_dword10, cmd_dword11, cmd_dword12, range_length} = '0;
        cmd_opcode = op_read;
        dealloc_read_feature_code = 3'h0;
        delay = 8'h00;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // never-written blocks read deallocated, twice alike, per feature code
        for (int c = 1; c <= 2; c++) begin
            dealloc_read_feature_code <= 3'(c);
            repeat (2) begin
                run_cmd(op_read, 3, 0);
                check(dq[0], 1'b1);
                check(pq[0], c == 2 ? pat_ones : pat_zeros);
                check(gq[0], c == 2 ? `GUARD_ONES : `GUARD_ZERO);
            end
        end
        // write two, read three: only the written ones lose the flag
        run_cmd(op_write, 5, 1);
        run_cmd(op_read, 5, 2);
        check(dq.size(), 3);
        for (int i = 0; i < 3; i++) begin
            check(dq[i], i == 2);
        end
        // deallocate exactly one block of the written pair
        run_cmd(op_dealloc, 5, 0, 1);
        check(got_status, `STATUS_SUCCESS);
        run_cmd(op_read, 5, 1);
        check(dq[0], 1'b1);
        check(dq[1], 1'b0);
        // unwritten error with support held on: only when enabled, only on deallocated blocks
        unwritten_err_supported <= 1'b1;
        for (int e = 0; e < 3; e++) begin
            unwritten_err_enabled <= e != 0;
            run_cmd(op_read, 5 + e / 2, 0);
            check(got_sct, e == 1 ? `SCT_MEDIA : `SCT_GENERIC);
            check(got_status, e == 1 ? `STATUS_UNWRITTEN : `STATUS_SUCCESS);
        end
        unwritten_err_enabled <= 1'b0;
        // deallocate errors: read-only, conflict, both (conflict wins)
        for (int k = 1; k < 4; k++) begin
            run_cmd(op_dealloc, 8, 0, 1, 2'(k));
            check(got_sct, `SCT_CMD_SPECIFIC);
            check(got_status, k == 1 ? `STATUS_READ_ONLY : `STATUS_CONFLICT);
        end
        // flush without cache, then with a prompt and a slow commit
        for (int k = 0; k < 3; k++) begin
            cache_enabled <= k != 0;
            delay <= 8'((k / 2) * 9);
            n_before = flushes;
            run_cmd(op_flush, 0, 0);
            check(got_status, `STATUS_SUCCESS);
            check(flushes - n_before, k != 0);
        end
        // sanitize hides written data again
        run_cmd(op_write, 7, 0);
        run_cmd(op_read, 7, 0);
        check(dq[0], 1'b0);
        while (cmd_ready !== 1'b1) @(posedge clk);
        sanitize_done <= 1'b1;
        @(posedge clk);
        sanitize_done <= 1'b0;
        run_cmd(op_read, 7, 0);
        check(dq[0], 1'b1);
        // read field decoding, page list then scatter list
        for (int s = 0; s < 2; s++) begin
            cmd_sgl <= s[0];
            run_cmd(op_read, 64'h0000_0001_0000_0002 << s, s ? 32'he800_0000 : 32'h0000_0004);
            check(first_block_address, 64'h0000_0001_0000_0002 << s);
            check(blocks_to_read, s ? 17'd1 : 17'd5);
            check({limited_retry_bit, force_media_access_bit}, s ? 2'b11 : 2'b00);
            check(protection_action_field, s ? 4'ha : 4'h0);
            check(uses_second_page_entry, s == 0);
        end
        report_and_stop();
    end
endmodule

bind dealloc_flush_read_cmd dealloc_checker #(.ADDR_W(ADDR_W), .COUNT_W(COUNT_W)) chk (.clk,
    .rst, .dealloc_read_feature_code, .cache_enabled, .cmd_valid, .cmd_ready, .cmd_opcode,
    .cmd_sgl, .cmd_dword10, .cmd_dword11, .cmd_dword12, .attr_conflict, .flush_req, .flush_done,
    .rd_info_valid, .first_block_address, .blocks_to_read, .limited_retry_bit,
    .force_media_access_bit, .protection_action_field, .uses_second_page_entry, .blk_valid,
    .blk_deallocated, .blk_pattern, .blk_guard, .blk_app_tag, .blk_ref_tag, .cpl_valid, .cpl_sct,
    .cpl_status);
